/* verilog/mclk_consts.vh */
// Constants for the master clock generator
`ifndef MCLK_CONSTS_VH
`define MCLK_CONSTS_VH
`define SRC_PLL_CODE 2'h3
`define SRC_BYPASS_BIT 1
`define IDIV_MAX 2'h3
`define ODIV_MAX 4'hE
`define MUL_W 5
`define VB_LOW 2'h0
`define VB_MID 2'h1
`define VB_HIGH 2'h2
`define VB_RESERVED 2'h3
`define VB_LOW_MIN_MHZ 100
`define VB_LOW_MAX_MHZ 150
`define VB_MID_MAX_MHZ 200
`define VB_HIGH_MAX_MHZ 250
`endif

/* verilog/master_clock_generation.v */
// Master clock generator: bypass prescalers, PLL model, CPU and system clock enables
`timescale 1ns/1ns
`default_nettype none
`include "mclk_consts.vh"
module master_clock_generation #(
    parameter MUL_W = `MUL_W
) (
    // Clock and reset
    input wire core_clk,
    input wire resetn,
    // Oscillator input, asynchronous to core_clk
    input wire oscillator_input_pin,
    // Configuration bits
    input wire [1:0] clock_source_select,
    input wire [1:0] input_prescale_field,
    input wire [3:0] output_prescale_field,
    input wire [MUL_W-1:0] feedback_multiplier_field,
    input wire [1:0] vco_band_select,
    input wire cpu_clock_halving_select,
    // Clock outputs as one-cycle enables on core_clk
    output reg master_clock_tick,
    output reg cpu_clock_tick,
    output reg system_clock_tick,
    // Status
    output reg pll_mode_active,
    output reg config_error
);
    // Frequencies are modelled as enable ticks: a tick per master clock edge.
    // The PLL is abstracted as (mul+1) ticks per input-divided oscillator edge.
    reg rst_sync1_reg;
    reg rst_sync2_reg;
    reg osc_sync1_reg;
    reg osc_sync2_reg;
    reg osc_prev_reg;
    reg [1:0] idiv_cnt_reg;
    reg [3:0] odiv_cnt_reg;
    reg [MUL_W:0] vco_pending_reg;
    reg cpu_phase_reg;
    reg [1:0] idiv_lim;
    reg [3:0] odiv_lim;
    reg osc_edge;
    reg in_tick;
    reg pre_tick;
    reg mc_next;
    reg [MUL_W:0] pend_next;
    reg [1:0] idiv_next;
    reg [3:0] odiv_next;
    wire rst_n = rst_sync2_reg;
    wire pll_sel = (clock_source_select == `SRC_PLL_CODE);
    wire bypass_sel = ~clock_source_select[`SRC_BYPASS_BIT];

    // Shared by the divider clamp and the error flag, so both agree on the limit
    function odiv_over_range;
        input [3:0] field;
        begin
            odiv_over_range = (field > `ODIV_MAX);
        end
    endfunction

    function band_reserved;
        input [1:0] band;
        begin
            band_reserved = (band == `VB_RESERVED);
        end
    endfunction

    // One gate for cpu and system ticks keeps the two clocks in step
    function cpu_pass;
        input tick;
        input halve;
        input phase;
        begin
            cpu_pass = tick & (~halve | phase);
        end
    endfunction

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end
        else
        begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    always @*
    begin
        // Out-of-range output divider is clamped rather than wrapped; the input divider field is used as is
        idiv_lim = input_prescale_field;
        odiv_lim = odiv_over_range(output_prescale_field) ? `ODIV_MAX : output_prescale_field;
        osc_edge = osc_sync2_reg & ~osc_prev_reg;
        in_tick = 1'b0;
        pre_tick = 1'b0;
        mc_next = 1'b0;
        idiv_next = idiv_cnt_reg;
        odiv_next = odiv_cnt_reg;
        pend_next = vco_pending_reg;
        if (osc_edge)
        begin
            if (idiv_cnt_reg >= idiv_lim)
            begin
                idiv_next = 2'h0;
                in_tick = 1'b1;
            end
            else
                idiv_next = idiv_cnt_reg + 2'h1;
        end
        if (pll_sel)
        begin
            // VCO edges: (mul+1) per divided input edge, drained one per cycle
            if (vco_pending_reg != {(MUL_W+1){1'b0}})
            begin
                pend_next = vco_pending_reg - 1'b1;
                pre_tick = 1'b1;
            end
            if (in_tick)
                pend_next = pend_next + {1'b0, feedback_multiplier_field} + 1'b1;
        end
        else if (bypass_sel)
        begin
            pre_tick = in_tick;
            pend_next = {(MUL_W+1){1'b0}};
        end
        else
            pend_next = {(MUL_W+1){1'b0}};
        if (pre_tick)
        begin
            if (odiv_cnt_reg >= odiv_lim)
            begin
                odiv_next = 4'h0;
                mc_next = 1'b1;
            end
            else
                odiv_next = odiv_cnt_reg + 4'h1;
        end
    end

    // Oscillator synchroniser; only the second stage feeds the edge detector
    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_sync1_reg <= 1'b0;
            osc_sync2_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end
        else
        begin
            osc_sync1_reg <= oscillator_input_pin;
            osc_sync2_reg <= osc_sync1_reg;
            osc_prev_reg <= osc_sync2_reg;
        end
    end

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idiv_cnt_reg <= 2'h0;
            odiv_cnt_reg <= 4'h0;
            vco_pending_reg <= {(MUL_W+1){1'b0}};
        end
        else
        begin
            idiv_cnt_reg <= idiv_next;
            odiv_cnt_reg <= odiv_next;
            vco_pending_reg <= pend_next;
        end
    end

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cpu_phase_reg <= 1'b0;
            master_clock_tick <= 1'b0;
            cpu_clock_tick <= 1'b0;
            system_clock_tick <= 1'b0;
        end
        else
        begin
            master_clock_tick <= mc_next;
            if (mc_next)
                cpu_phase_reg <= cpu_clock_halving_select ? ~cpu_phase_reg : 1'b0;
            // Halving passes every second master tick
            cpu_clock_tick <= cpu_pass(mc_next, cpu_clock_halving_select, cpu_phase_reg);
            system_clock_tick <= cpu_pass(mc_next, cpu_clock_halving_select, cpu_phase_reg);
        end
    end

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pll_mode_active <= 1'b0;
            config_error <= 1'b0;
        end
        else
        begin
            pll_mode_active <= pll_sel;
            // Reserved band is only flagged; ticks keep running so software can still see it
            config_error <= (pll_sel & band_reserved(vco_band_select)) |
                odiv_over_range(output_prescale_field);
        end
    end
endmodule
`default_nettype wire

/* dv/mclk_checker.sv */
// Port checker for the master clock generator
`timescale 1ns/1ns
`default_nettype none
module mclk_checker(
    // Inputs
    input wire logic core_clk, resetn, cpu_clock_halving_select,
    input wire logic [1:0] clock_source_select, vco_band_select,
    input wire logic [3:0] output_prescale_field,
    // Outputs
    input wire logic master_clock_tick, cpu_clock_tick, system_clock_tick, pll_mode_active, config_error
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Internal reset trails the pin by two cycles and status lags one more
    logic [1:0] settle_cnt;
    always @(posedge core_clk or negedge resetn)
        if (!resetn)
            settle_cnt <= 2'h0;
        else if (settle_cnt != 2'h3)
            settle_cnt <= settle_cnt + 2'h1;
    wire settled = (settle_cnt == 2'h3);
    // Long enough to cover the internal reset release
    sequence held;
        $stable({clock_source_select, output_prescale_field, vco_band_select})[*6];
    endsequence
    sequence full_rate;
        (!cpu_clock_halving_select)[*3];
    endsequence
    wire bad = output_prescale_field == 4'hF || (clock_source_select == 2'h3 && vco_band_select == 2'h3);
    chk_sys_cpu: assert property (system_clock_tick == cpu_clock_tick)
        else $error("system tick differs");
    chk_cpu_master: assert property (cpu_clock_tick |-> master_clock_tick)
        else $error("cpu tick alone");
    chk_full_rate: assert property (full_rate ##0 master_clock_tick |-> cpu_clock_tick)
        else $error("cpu tick missed");
    chk_half_rate: assert property (cpu_clock_halving_select[*3] ##0 cpu_clock_tick |=> !cpu_clock_tick)
        else $error("cpu tick at full rate");
    chk_pll_flag: assert property (held ##0 settled |-> pll_mode_active == (clock_source_select == 2'h3))
        else $error("pll flag wrong");
    chk_stop_quiet: assert property ((clock_source_select == 2'h2)[*8] |-> !master_clock_tick)
        else $error("tick while stopped");
    chk_bypass_gap: assert property ((!clock_source_select[1])[*3] ##0 master_clock_tick |=> !master_clock_tick)
        else $error("bypass ticks adjacent");
    chk_config_err: assert property (held ##0 settled |-> config_error == bad)
        else $error("config error wrong");
endmodule
`default_nettype wire

/* dv/osc_source.sv */
// Oscillator model, idle low between bursts
`timescale 1ns/1ns
`default_nettype none
module osc_source(output var logic osc);
    initial osc = 1'b0;
    task automatic run(input int n, input int half);
        repeat (n)
        begin
            osc = 1'b1;
            #half;
            osc = 1'b0;
            #half;
        end
    endtask
endmodule
`default_nettype wire

/* dv/tb_master_clock_generation.sv */
// Self-checking bench for the master clock generator
`timescale 1ns/1ns
`default_nettype none
module tb_master_clock_generation;
    logic core_clk = 0, resetn = 0, halve = 0;
    logic [1:0] sel = 0, idiv = 0, vb = 0;
    logic [3:0] odiv = 0;
    logic [4:0] mul = 0;
    logic [31:0] rnd = 32'hA59C;
    wire osc, mt, ct, st, pa, ce;
    int errors = 0, comparisons = 0, nm = 0, nc = 0, ns = 0, bm = 0, bc = 0, bs = 0, i, m;
    osc_source src(.osc(osc));
    master_clock_generation dut(.core_clk(core_clk), .resetn(resetn), .oscillator_input_pin(osc),
        .clock_source_select(sel), .input_prescale_field(idiv), .output_prescale_field(odiv),
        .feedback_multiplier_field(mul), .vco_band_select(vb), .cpu_clock_halving_select(halve),
        .master_clock_tick(mt), .cpu_clock_tick(ct), .system_clock_tick(st), .pll_mode_active(pa),
        .config_error(ce));
    initial forever #4 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        nm <= nm + mt;
        nc <= nc + ct;
        ns <= ns + st;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task check(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task final_report;
        if (errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #700000 errors++;
        final_report;
    end
    initial
    begin
        for (i = 0; i < 24; i++)
        begin
            if (i > 0) repeat (8) @(posedge core_clk);
            #1 resetn = 0;
            rnd = xs(rnd);
            sel = i[1:0];
            {halve, vb, odiv, idiv} = rnd[8:0];
            mul = {2'h0, rnd[11:9]};
            if (i < 2) {odiv, idiv} = 6'h00;
            if (i == 4) {odiv, idiv} = 6'h3B;
            repeat (8) @(posedge core_clk);
            #1 resetn = 1;
            repeat (8) @(posedge core_clk);
            #1 bm = nm;
            bc = nc;
            bs = ns;
            // Period of 2*(mul+2) cycles keeps the VCO pending count from wrapping
            src.run(120, 8 * (mul + 2));
            repeat (200) @(posedge core_clk);
            m = (odiv == 4'hF) ? 15 : odiv + 1;
            if (sel == 2'h3) m = 120 / (idiv + 1) * (mul + 1) / m;
            else if (sel == 2'h2) m = 0;
            else m = 120 / (idiv + 1) / m;
            if (!(sel == 2'h3 && vb == 2'h3))
            begin
                check("master ticks", nm - bm, m);
                check("cpu ticks", nc - bc, halve ? m / 2 : m);
                check("system ticks", ns - bs, halve ? m / 2 : m);
            end
            check("pll flag", pa, sel == 2'h3);
            check("config error", ce, odiv == 4'hF || (sel == 2'h3 && vb == 2'h3));
        end
        final_report;
    end
endmodule
bind master_clock_generation mclk_checker chk(.*);
`default_nettype wire
